/* bench/mode_select_mfg_test_tb_top.sv */
// testbench for start-up mode selection and pin test commands
`timescale 1ns/100ps
`default_nettype none
module mode_select_mfg_test_tb_top import msmt_pkg::*;;
   logic clk, rst_n, sense, cbw_v, dout_v, din_rdy, ee_pres, ee_req, ee_wr, ee_done, ee_nack;
   logic din_v, dout_rdy, busy, done, fail, pass, mvalid, leg, usef, defd, ata, ctrl_oe, dd_oe;
   logic [31:0] fuse;
   logic [7:0] dout_d, din_d, ee_addr, ee_wd, ee_rd;
   logic [7:0] wbuf [256];
   logic [7:0] buf_q [$];
   msmt_cbw_type cbw;
   msmt_pin_in_type pin_in;
   msmt_mode_type mode;
   msmt_pins_type pins;
   int errors, checks;
   // ==========================================================================
   // design, eeprom and clock
   msmt_core msmt_core_inst (.MCLK_IN(clk), .RESET_N_IN(rst_n), .RESET_LINE_SENSE_IN(sense), .FUSE_IDS_IN(fuse),
      .EE_REQ_OUT(ee_req), .EE_WRITE_OUT(ee_wr), .EE_ADDR_OUT(ee_addr), .EE_WDATA_OUT(ee_wd), .EE_DONE_IN(ee_done),
      .EE_NACK_IN(ee_nack), .EE_RDATA_IN(ee_rd), .CBW_VALID_IN(cbw_v), .CBW_IN(cbw), .DOUT_VALID_IN(dout_v),
      .DOUT_DATA_IN(dout_d), .DOUT_READY_OUT(dout_rdy), .DIN_VALID_OUT(din_v), .DIN_DATA_OUT(din_d),
      .DIN_READY_IN(din_rdy), .CMD_BUSY_OUT(busy), .CMD_DONE_OUT(done), .CMD_FAIL_OUT(fail), .CMD_PASS_OUT(pass),
      .MODE_VALID_OUT(mvalid), .MODE_OUT(mode), .LEGACY_FORMAT_OUT(leg), .USE_FUSE_OUT(usef),
      .DEFAULT_DESC_OUT(defd), .ATA_ACTIVE_OUT(ata), .PIN_IN(pin_in), .PIN_OUT(pins), .PIN_CTRL_OE_OUT(ctrl_oe),
      .PIN_DD_OE_OUT(dd_oe));
   msmt_ee_model msmt_ee_model_inst (.clk_in(clk), .rst_n_in(rst_n), .present_in(ee_pres), .req_in(ee_req),
      .write_in(ee_wr), .addr_in(ee_addr), .wdata_in(ee_wd), .done_out(ee_done), .nack_out(ee_nack),
      .rdata_out(ee_rd));
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ==========================================================================
   // tasks
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // 12-cycle reset, wait for mode
   task automatic boot(logic pres, logic [15:0] sig, logic strap, logic [31:0] fz);
      int n;
      @(posedge clk);
      rst_n <= 1'b0;
      ee_pres <= pres;
      sense <= strap;
      fuse <= fz;
      msmt_ee_model_inst.mem[0] = sig[15:8];
      msmt_ee_model_inst.mem[1] = sig[7:0];
      msmt_ee_model_inst.mem[4] = 8'h24;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      for (n = 0; !(mvalid === 1'b1 && busy === 1'b0); n++) begin
         @(posedge clk);
         if (n > 300) begin
            errors++;
            summarize();
         end
      end
   endtask
   // one wrapper; on reads the host stalls every third cycle
   task automatic xfer(input logic [7:0] b0, b1, b3, input logic [31:0] len, input logic rd, output logic [2:0] r);
      int n, k;
      @(posedge clk);
      cbw_v <= 1'b1;
      cbw <= '{cb: {96'h0, b3, 8'h00, b1, b0}, len: len, flags: {rd, 7'h00}};
      @(posedge clk);
      cbw_v <= 1'b0;
      pin_in <= ~pin_in; // snapshot is of the request edge
      buf_q = {};
      r = 3'b000;
      k = 0;
      for (n = 1; r == 3'b000; n++) begin
         @(posedge clk);
         if (done === 1'b1 || pass === 1'b1) r = {done, fail, pass};
         if (dout_v && dout_rdy === 1'b1) k++;
         if (din_v === 1'b1 && din_rdy) buf_q.push_back(din_d);
         if (n > 5000) begin
            errors++;
            summarize();
         end
         if (r == 3'b000) begin
            dout_v <= !rd && k < len;
            dout_d <= wbuf[k[7:0]];
            din_rdy <= rd && (n % 3 != 0);
         end
      end
      dout_v <= 1'b0;
      din_rdy <= 1'b0;
   endtask
   // ==========================================================================
   // start-up table, then test commands
   initial begin
      logic [2:0] r;
      msmt_pin_in_type p;
      {rst_n, sense, cbw_v, dout_v, din_rdy, ee_pres, fuse, dout_d, cbw, pin_in} = '0;
      errors = 0;
      checks = 0;
      for (int i = 0; i < 6; i++) begin
         boot(6'b111100 >> i & 1, 96'h1234_534B_534B_4D4D_0000_0000 >> 16 * i, i != 4, (i == 1) ? 0 : 32'h1234_5678);
         chk("mode", {mode, leg, defd}, 24'h88_0690 >> 4 * i & 4'hF);
         if (i == 0) chk("fuse", usef, 1'b1);
         if (i == 3) begin
            xfer(8'h24, MSMT_SUB_PIN, 8'h00, 4, 1'b1, r);
            chk("normal pass", r, 3'b001);
         end
      end
      // pin snapshot, then zero
      p = 30'h2A5A_C35A;
      pin_in <= p;
      xfer(8'h24, MSMT_SUB_PIN, 8'h00, 5, 1'b1, r);
      chk("rd res", r, 3'b100);
      chk("rd n", buf_q.size(), 5);
      chk("rd b0", buf_q[0], {p.drive_reset_line_n, p.da2, p.cs_n, p.drive_power_valid, p.da, p.intrq});
      chk("rd b1", buf_q[1], {2'b01, p.bus_power_to_drive_en, p.dmarq, p.iordy, p.dmack_n, p.dior_n, p.diow_n});
      chk("rd dd", {buf_q[4], buf_q[3], buf_q[2]}, {8'h00, p.dd[15:8], p.dd[7:0]});
      // pin loads: drive then float data; byte 4 dropped
      for (int j = 0; j < 2; j++) begin
         wbuf[0] = 8'hA5;
         wbuf[1] = j ? 8'h05 : 8'h85;
         wbuf[2] = 8'h3C;
         wbuf[3] = 8'hC3;
         wbuf[4] = 8'hFF;
         xfer(8'h24, MSMT_SUB_PIN, 8'h00, 5, 1'b0, r);
         repeat (2) @(posedge clk);
         chk("ld res", r, 3'b100);
         chk("pins", pins, 32'h0195_C33C);
         chk("oe", {ctrl_oe, dd_oe, mode}, {1'b1, j == 0, MSMT_MODE_MFG});
      end
      // config write then read back
      wbuf[0] = 8'h11;
      wbuf[1] = 8'h22;
      xfer(8'h24, MSMT_SUB_CFG, MSMT_SRC_EEPROM, 2, 1'b0, r);
      chk("cfg wr", {r, msmt_ee_model_inst.mem[0], msmt_ee_model_inst.mem[1]}, {3'b100, 16'h1122});
      xfer(8'h24, MSMT_SUB_CFG, MSMT_SRC_EEPROM, 2, 1'b1, r);
      chk("cfg rd", {r, buf_q[0], buf_q[1]}, {3'b100, 16'h1122});
      // refusals, then wrappers passed on
      xfer(8'h24, MSMT_SUB_CFG, 8'h01, 2, 1'b1, r);
      chk("bad src", r, 3'b110);
      xfer(8'h24, MSMT_SUB_CFG, MSMT_SRC_EEPROM, 256, 1'b1, r);
      chk("long", r, 3'b110);
      xfer(8'h25, MSMT_SUB_PIN, 8'h00, 4, 1'b1, r);
      chk("desig", r, 3'b001);
      xfer(8'h24, 8'h28, 8'h00, 4, 1'b1, r);
      chk("sub", {r, mode}, {3'b001, MSMT_MODE_MFG});
      summarize();
   end
endmodule
`default_nettype wire

/* bench/msmt_chk.sv */
// assertion checker for the mode select and pin test core
`timescale 1ns/100ps
`default_nettype none
module msmt_chk import msmt_pkg::*; (
   // clock and reset
   input wire logic MCLK_IN,
   input wire logic RESET_N_IN,
   // command side
   input wire logic CBW_VALID_IN,
   input wire msmt_cbw_type CBW_IN,
   input wire logic CMD_BUSY_OUT,
   input wire logic CMD_DONE_OUT,
   input wire logic CMD_FAIL_OUT,
   input wire logic CMD_PASS_OUT,
   input wire logic DIN_VALID_OUT,
   input wire logic [7:0] DIN_DATA_OUT,
   input wire logic DIN_READY_IN,
   // eeprom and mode side
   input wire logic EE_REQ_OUT,
   input wire logic EE_WRITE_OUT,
   input wire logic [7:0] EE_ADDR_OUT,
   input wire logic MODE_VALID_OUT,
   input wire msmt_mode_type MODE_OUT,
   input wire logic LEGACY_FORMAT_OUT,
   input wire logic DEFAULT_DESC_OUT,
   input wire logic ATA_ACTIVE_OUT,
   input wire logic PIN_CTRL_OE_OUT,
   input wire logic PIN_DD_OE_OUT
);
   // ==========================================================================
   // one clock domain
   default clocking cb_main @(posedge MCLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);
   // wrapper taken only when idle after start-up
   sequence s_taken;
      CBW_VALID_IN && !CMD_BUSY_OUT && MODE_VALID_OUT;
   endsequence
   sequence s_refused;
      ##[1:2] (CMD_PASS_OUT || (CMD_DONE_OUT && CMD_FAIL_OUT));
   endsequence
   AST_BOOT_PROBE: assert property ($rose(RESET_N_IN) |-> ##[1:3] (EE_REQ_OUT && !EE_WRITE_OUT && EE_ADDR_OUT == 8'h00))
      else $error("bad first probe");
   AST_NOT_MFG_PASS: assert property (s_taken and MODE_OUT != MSMT_MODE_MFG |-> ##[1:2] CMD_PASS_OUT)
      else $error("no pass outside test mode");
   AST_CFG_TOO_LONG: assert property (s_taken and CBW_IN.cb[15:8] == MSMT_SUB_CFG && CBW_IN.len > MSMT_CFG_MAX |-> s_refused)
      else $error("overlong accepted");
   AST_WRONG_SUB: assert property (s_taken and CBW_IN.cb[15:8] != MSMT_SUB_CFG && CBW_IN.cb[15:8] != MSMT_SUB_PIN |-> ##[1:2] CMD_PASS_OUT)
      else $error("unknown sub not passed");
   AST_MFG_STICKY: assert property (MODE_VALID_OUT && MODE_OUT == MSMT_MODE_MFG |=> MODE_OUT == MSMT_MODE_MFG)
      else $error("test mode left");
   AST_OE_STICKY: assert property (PIN_CTRL_OE_OUT |=> PIN_CTRL_OE_OUT && MODE_OUT == MSMT_MODE_MFG)
      else $error("override dropped");
   AST_DD_FLOAT: assert property (!PIN_CTRL_OE_OUT |-> !PIN_DD_OE_OUT)
      else $error("data driven unloaded");
   AST_DIN_HOLD: assert property (DIN_VALID_OUT && !DIN_READY_IN |=> DIN_VALID_OUT && $stable(DIN_DATA_OUT))
      else $error("read byte changed");
   AST_ATA_IDLE: assert property (MODE_VALID_OUT |-> ATA_ACTIVE_OUT == (MODE_OUT != MSMT_MODE_MFG))
      else $error("drive activity vs mode");
   AST_LEGACY_FMT: assert property (MODE_VALID_OUT && MODE_OUT == MSMT_MODE_LEGACY |-> LEGACY_FORMAT_OUT)
      else $error("legacy without format");
   AST_DEFAULT_MFG: assert property (MODE_VALID_OUT && DEFAULT_DESC_OUT |-> MODE_OUT == MSMT_MODE_MFG)
      else $error("default desc not test");
endmodule
bind msmt_core msmt_chk msmt_chk_inst (.*);
`default_nettype wire

/* bench/msmt_ee_model.sv */
// behavioural eeprom byte engine
`timescale 1ns/100ps
`default_nettype none
module msmt_ee_model #(parameter int DELAY = 3) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // requests from the core
   input wire logic present_in,
   input wire logic req_in,
   input wire logic write_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   // answers
   output logic done_out,
   output logic nack_out,
   output logic [7:0] rdata_out
);
   logic [7:0] mem [256];
   logic [7:0] addr_q;
   logic [7:0] wd_q;
   logic wr_q;
   int cnt;
   // fixed delay; read data valid only with done
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt <= 0;
         done_out <= 1'b0;
         nack_out <= 1'b0;
         rdata_out <= 8'h00;
      end else begin
         done_out <= 1'b0;
         nack_out <= 1'b0;
         rdata_out <= ~rdata_out;
         if (req_in) begin
            cnt <= DELAY;
            addr_q <= addr_in;
            wd_q <= wdata_in;
            wr_q <= write_in;
         end else if (cnt == 1) begin
            cnt <= 0;
            done_out <= 1'b1;
            nack_out <= !present_in; // absent: no ack
            rdata_out <= mem[addr_q];
            if (wr_q && present_in) mem[addr_q] <= wd_q;
         end else if (cnt > 1) cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

/* core/msmt_cb_decode.sv */
// command block decoder for the config and pin test vendor commands
`timescale 1ns/100ps
`default_nettype none
module msmt_cb_decode import msmt_pkg::*; (
   // command block and designator
   input wire logic [127:0] cb_in,
   input wire logic [7:0] desig_in,
   // decode results
   output logic is_cfg_out,
   output logic is_pin_out,
   output logic cfg_ok_out,
   output logic pin_ok_out
);
   // byte i of the block sits at bits 8*i+7:8*i
   function automatic logic [7:0] cb_byte(input logic [127:0] cb, input int idx);
      cb_byte = cb[8*idx +: 8];
   endfunction

   // ==========================================================================
   // field checks
   always_comb begin
      logic desig_hit;
      logic zero_2_15;
      logic zero_6_15;
      desig_hit = (cb_byte(cb_in, 0) == desig_in);
      zero_2_15 = (cb_in[127:16] == 112'h0);
      zero_6_15 = (cb_in[127:48] == 80'h0);
      is_cfg_out = desig_hit && (cb_byte(cb_in, 1) == MSMT_SUB_CFG);
      is_pin_out = desig_hit && (cb_byte(cb_in, 1) == MSMT_SUB_PIN);
      // malformed blocks are refused rather than guessed at
      cfg_ok_out = (cb_byte(cb_in, 2) == 8'h00) && (cb_byte(cb_in, 3) == MSMT_SRC_EEPROM)
         && (cb_byte(cb_in, 4) == 8'h00) && (cb_byte(cb_in, 5) == 8'h00) && zero_6_15;
      pin_ok_out = zero_2_15;
   end
endmodule
`default_nettype wire

/* core/msmt_core.sv */
// start-up mode selection and vendor command interpreter
`timescale 1ns/100ps
`default_nettype none
module msmt_core import msmt_pkg::*; (
   // clock and reset
   input wire logic MCLK_IN,
   input wire logic RESET_N_IN,
   // start-up inputs
   input wire logic RESET_LINE_SENSE_IN,
   input wire logic [31:0] FUSE_IDS_IN,
   // eeprom byte engine
   output logic EE_REQ_OUT,
   output logic EE_WRITE_OUT,
   output logic [7:0] EE_ADDR_OUT,
   output logic [7:0] EE_WDATA_OUT,
   input wire logic EE_DONE_IN,
   input wire logic EE_NACK_IN,
   input wire logic [7:0] EE_RDATA_IN,
   // command wrapper in
   input wire logic CBW_VALID_IN,
   input wire msmt_cbw_type CBW_IN,
   // host to device data
   input wire logic DOUT_VALID_IN,
   input wire logic [7:0] DOUT_DATA_IN,
   output logic DOUT_READY_OUT,
   // device to host data
   output logic DIN_VALID_OUT,
   output logic [7:0] DIN_DATA_OUT,
   input wire logic DIN_READY_IN,
   // command status
   output logic CMD_BUSY_OUT,
   output logic CMD_DONE_OUT,
   output logic CMD_FAIL_OUT,
   output logic CMD_PASS_OUT,
   // mode status
   output logic MODE_VALID_OUT,
   output msmt_mode_type MODE_OUT,
   output logic LEGACY_FORMAT_OUT,
   output logic USE_FUSE_OUT,
   output logic DEFAULT_DESC_OUT,
   output logic ATA_ACTIVE_OUT,
   // pin test
   input wire msmt_pin_in_type PIN_IN,
   output msmt_pins_type PIN_OUT,
   output logic PIN_CTRL_OE_OUT,
   output logic PIN_DD_OE_OUT
);
   // ==========================================================================
   // state
   typedef struct packed {
      msmt_state_type st;
      msmt_mode_type mode;
      logic valid;
      logic legacy;
      logic use_fuse;
      logic dflt_desc;
      logic strap_low;
      logic ee_present;
      logic [15:0] sig;
      logic [7:0] desig;
      logic [31:0] len;
      logic [31:0] cnt;
      logic pin_cmd;
      logic err;
      logic ee_req;
      logic ee_wr;
      logic [7:0] ee_addr;
      logic [7:0] ee_wdata;
      logic dout_ready;
      logic din_valid;
      logic [7:0] din_data;
      logic [31:0] load;
      logic [31:0] snap;
      logic override;
      msmt_pins_type pins;
      logic dd_oe;
      logic done;
      logic fail;
      logic pass;
   } msmt_core_type;

   msmt_core_type core_reg;
   msmt_core_type core_next;

   logic is_cfg;
   logic is_pin;
   logic cfg_ok;
   logic pin_ok;
   msmt_pins_type map_pins;
   logic map_dd_drive;
   logic [31:0] map_snap;

   // byte idx of a pin test word; bytes past 3 carry no meaning
   function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [31:0] idx);
      if (idx < MSMT_PIN_BYTES) begin
         word_byte = w[8*idx[1:0] +: 8];
      end else begin
         word_byte = 8'h00;
      end
   endfunction

   // ==========================================================================
   // decoders
   msmt_cb_decode u_decode (
      .cb_in(CBW_IN.cb),
      .desig_in(core_reg.desig),
      .is_cfg_out(is_cfg),
      .is_pin_out(is_pin),
      .cfg_ok_out(cfg_ok),
      .pin_ok_out(pin_ok)
   );

   msmt_pin_map u_pin_map (
      .load_in(core_reg.load),
      .pin_in(PIN_IN),
      .mfg_in(core_reg.mode == MSMT_MODE_MFG),
      .pins_out(map_pins),
      .dd_drive_out(map_dd_drive),
      .snap_out(map_snap)
   );

   // ==========================================================================
   // next state
   always_comb begin
      core_next = core_reg;
      core_next.ee_req = 1'b0;
      core_next.done = 1'b0;
      core_next.fail = 1'b0;
      core_next.pass = 1'b0;
      // pins follow the loaded word one cycle later so outputs stay registered
      core_next.pins = map_pins;
      core_next.dd_oe = core_reg.override & map_dd_drive;
      case (core_reg.st)
         MSMT_ST_STRAP: begin
            // strap taken at the first edge after release
            core_next.strap_low = ~RESET_LINE_SENSE_IN;
            core_next.ee_req = 1'b1;
            core_next.ee_wr = 1'b0;
            core_next.ee_addr = MSMT_SIG0_ADDR;
            core_next.st = MSMT_ST_SIG0;
         end
         MSMT_ST_SIG0: begin
            if (EE_DONE_IN) begin
               if (EE_NACK_IN) begin
                  core_next.ee_present = 1'b0;
                  core_next.st = MSMT_ST_DECIDE;
               end else begin
                  core_next.ee_present = 1'b1;
                  core_next.sig[15:8] = EE_RDATA_IN;
                  core_next.ee_req = 1'b1;
                  core_next.ee_addr = MSMT_SIG1_ADDR;
                  core_next.st = MSMT_ST_SIG1;
               end
            end
         end
         MSMT_ST_SIG1: begin
            if (EE_DONE_IN) begin
               core_next.sig[7:0] = EE_RDATA_IN;
               core_next.ee_req = 1'b1;
               core_next.ee_addr = MSMT_DESIG_ADDR;
               core_next.st = MSMT_ST_DESIG;
            end
         end
         MSMT_ST_DESIG: begin
            if (EE_DONE_IN) begin
               core_next.desig = EE_RDATA_IN;
               core_next.st = MSMT_ST_DECIDE;
            end
         end
         MSMT_ST_DECIDE: begin
            // eeprom outcome first, then signature, then the strap overrides
            if (!core_reg.ee_present) begin
               core_next.use_fuse = 1'b1;
               if (FUSE_IDS_IN == MSMT_FUSE_BLANK) begin
                  core_next.mode = MSMT_MODE_MFG;
                  core_next.dflt_desc = 1'b1;
               end else begin
                  core_next.mode = MSMT_MODE_NORMAL;
               end
            end else if (core_reg.sig == MSMT_SIG_LEGACY) begin
               core_next.mode = MSMT_MODE_LEGACY;
               core_next.legacy = 1'b1;
            end else if (core_reg.sig == MSMT_SIG_NORMAL) begin
               core_next.mode = MSMT_MODE_NORMAL;
            end else begin
               core_next.mode = MSMT_MODE_MFG;
            end
            if (core_reg.strap_low) begin
               core_next.mode = MSMT_MODE_MFG;
            end
            core_next.valid = 1'b1;
            core_next.st = MSMT_ST_IDLE;
         end
         MSMT_ST_IDLE: begin
            if (CBW_VALID_IN) begin
               core_next.len = CBW_IN.len;
               core_next.cnt = 32'h0000_0000;
               core_next.err = 1'b0;
               core_next.pin_cmd = is_pin;
               core_next.ee_wr = ~CBW_IN.flags[MSMT_DIR_BIT];
               if (core_reg.mode != MSMT_MODE_MFG || !(is_cfg || is_pin)) begin
                  // not ours: the mass storage path takes it
                  core_next.pass = 1'b1;
               end else if (is_cfg && (!cfg_ok || CBW_IN.len > MSMT_CFG_MAX)) begin
                  core_next.done = 1'b1;
                  core_next.fail = 1'b1;
               end else if (is_pin && !pin_ok) begin
                  core_next.done = 1'b1;
                  core_next.fail = 1'b1;
               end else if (CBW_IN.len == 32'h0000_0000) begin
                  core_next.done = 1'b1;
               end else if (is_cfg && CBW_IN.flags[MSMT_DIR_BIT]) begin
                  core_next.ee_req = 1'b1;
                  core_next.ee_addr = 8'h00;
                  core_next.st = MSMT_ST_CFG_RD;
               end else if (is_cfg) begin
                  core_next.dout_ready = 1'b1;
                  core_next.st = MSMT_ST_CFG_GET;
               end else if (CBW_IN.flags[MSMT_DIR_BIT]) begin
                  // snapshot taken now
                  core_next.snap = map_snap;
                  core_next.din_data = word_byte(map_snap, 32'h0000_0000);
                  core_next.din_valid = 1'b1;
                  core_next.st = MSMT_ST_SEND;
               end else begin
                  core_next.dout_ready = 1'b1;
                  core_next.st = MSMT_ST_PIN_GET;
               end
            end
         end
         MSMT_ST_CFG_GET: begin
            if (DOUT_VALID_IN && core_reg.dout_ready) begin
               core_next.dout_ready = 1'b0;
               core_next.ee_req = 1'b1;
               core_next.ee_addr = core_reg.cnt[7:0];
               core_next.ee_wdata = DOUT_DATA_IN;
               core_next.st = MSMT_ST_CFG_WR;
            end
         end
         MSMT_ST_CFG_WR: begin
            if (EE_DONE_IN) begin
               core_next.err = core_reg.err | EE_NACK_IN;
               core_next.cnt = core_reg.cnt + 32'h0000_0001;
               if (core_reg.cnt + 32'h0000_0001 == core_reg.len) begin
                  core_next.done = 1'b1;
                  core_next.fail = core_reg.err | EE_NACK_IN;
                  core_next.st = MSMT_ST_IDLE;
               end else begin
                  core_next.dout_ready = 1'b1;
                  core_next.st = MSMT_ST_CFG_GET;
               end
            end
         end
         MSMT_ST_CFG_RD: begin
            if (EE_DONE_IN) begin
               core_next.err = core_reg.err | EE_NACK_IN;
               core_next.din_data = EE_RDATA_IN;
               core_next.din_valid = 1'b1;
               core_next.st = MSMT_ST_SEND;
            end
         end
         MSMT_ST_SEND: begin
            if (DIN_READY_IN) begin
               core_next.din_valid = 1'b0;
               core_next.cnt = core_reg.cnt + 32'h0000_0001;
               if (core_reg.cnt + 32'h0000_0001 == core_reg.len) begin
                  core_next.done = 1'b1;
                  core_next.fail = core_reg.err;
                  core_next.st = MSMT_ST_IDLE;
               end else if (core_reg.pin_cmd) begin
                  core_next.din_data = word_byte(core_reg.snap, core_reg.cnt + 32'h0000_0001);
                  core_next.din_valid = 1'b1;
               end else begin
                  core_next.ee_req = 1'b1;
                  core_next.ee_addr = core_reg.cnt[7:0] + 8'h01;
                  core_next.st = MSMT_ST_CFG_RD;
               end
            end
         end
         MSMT_ST_PIN_GET: begin
            if (DOUT_VALID_IN && core_reg.dout_ready) begin
               if (core_reg.cnt < MSMT_PIN_BYTES) begin
                  core_next.load[8*core_reg.cnt[1:0] +: 8] = DOUT_DATA_IN;
               end
               core_next.cnt = core_reg.cnt + 32'h0000_0001;
               if (core_reg.cnt + 32'h0000_0001 == core_reg.len) begin
                  // pins switch over once the whole packet is in
                  core_next.dout_ready = 1'b0;
                  core_next.mode = MSMT_MODE_MFG;
                  core_next.override = 1'b1;
                  core_next.done = 1'b1;
                  core_next.st = MSMT_ST_IDLE;
               end
            end
         end
         default: begin
            core_next.st = MSMT_ST_IDLE;
         end
      endcase
   end

   // ==========================================================================
   // state register; only reset clears the mode and the override
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         core_reg <= '0;
         core_reg.st <= MSMT_ST_STRAP;
         core_reg.mode <= MSMT_MODE_NORMAL;
         core_reg.desig <= MSMT_DESIG_DEFAULT;
      end else begin
         core_reg <= core_next;
      end
   end

   // ==========================================================================
   // outputs
   assign EE_REQ_OUT = core_reg.ee_req;
   assign EE_WRITE_OUT = core_reg.ee_wr;
   assign EE_ADDR_OUT = core_reg.ee_addr;
   assign EE_WDATA_OUT = core_reg.ee_wdata;
   assign DOUT_READY_OUT = core_reg.dout_ready;
   assign DIN_VALID_OUT = core_reg.din_valid;
   assign DIN_DATA_OUT = core_reg.din_data;
   assign CMD_BUSY_OUT = core_reg.st != MSMT_ST_IDLE;
   assign CMD_DONE_OUT = core_reg.done;
   assign CMD_FAIL_OUT = core_reg.fail;
   assign CMD_PASS_OUT = core_reg.pass;
   assign MODE_VALID_OUT = core_reg.valid;
   assign MODE_OUT = core_reg.mode;
   assign LEGACY_FORMAT_OUT = core_reg.legacy;
   assign USE_FUSE_OUT = core_reg.use_fuse;
   assign DEFAULT_DESC_OUT = core_reg.dflt_desc;
   assign ATA_ACTIVE_OUT = core_reg.valid & (core_reg.mode != MSMT_MODE_MFG);
   assign PIN_OUT = core_reg.pins;
   assign PIN_CTRL_OE_OUT = core_reg.override;
   assign PIN_DD_OE_OUT = core_reg.dd_oe;
endmodule
`default_nettype wire

/* core/msmt_pin_map.sv */
// pin test word to pins, and input snapshot
`timescale 1ns/100ps
`default_nettype none
module msmt_pin_map import msmt_pkg::*; (
   // loaded data bytes 0..3, byte 0 in the low bits
   input wire logic [31:0] load_in,
   input wire msmt_pin_in_type pin_in,
   input wire logic mfg_in,
   // results
   output msmt_pins_type pins_out,
   output logic dd_drive_out,
   output logic [31:0] snap_out
);
   // ==========================================================================
   // load: read-only positions (byte 0 bits 6,0, byte 1 bits 6:3) are dropped
   always_comb begin
      pins_out.drive_reset_line_n = load_in[7];
      pins_out.cs_n = load_in[5:4];
      pins_out.drive_power_valid = load_in[3];
      pins_out.da = load_in[2:1];
      pins_out.dmack_n = load_in[10];
      pins_out.dior_n = load_in[9];
      pins_out.diow_n = load_in[8];
      pins_out.dd = load_in[31:16];
      dd_drive_out = load_in[MSMT_DD_DRIVE_BIT];
   end

   // ==========================================================================
   // snapshot: load-only bit (byte 1 bit 7) reads zero
   always_comb begin
      snap_out[7:0] = {pin_in.drive_reset_line_n, pin_in.da2, pin_in.cs_n,
         pin_in.drive_power_valid, pin_in.da, pin_in.intrq};
      snap_out[15:8] = {1'b0, mfg_in, pin_in.bus_power_to_drive_en, pin_in.dmarq,
         pin_in.iordy, pin_in.dmack_n, pin_in.dior_n, pin_in.diow_n};
      snap_out[31:16] = pin_in.dd;
   end
endmodule
`default_nettype wire

/* core/msmt_pkg.sv */
// constants and carrier types for mode select and pin test
// ==========================================================================
package msmt_pkg;
   // ==========================================================================
   // signatures and eeprom addresses
   localparam logic [15:0] MSMT_SIG_NORMAL = 16'h534B;
   localparam logic [15:0] MSMT_SIG_LEGACY = 16'h4D4D;
   localparam logic [7:0] MSMT_SIG0_ADDR = 8'h00;
   localparam logic [7:0] MSMT_SIG1_ADDR = 8'h01;
   localparam logic [7:0] MSMT_DESIG_ADDR = 8'h04;
   localparam logic [7:0] MSMT_DESIG_DEFAULT = 8'h24;
   localparam logic [31:0] MSMT_FUSE_BLANK = 32'h0000_0000;
   // ==========================================================================
   // command block fields
   localparam logic [7:0] MSMT_SUB_CFG = 8'h26;
   localparam logic [7:0] MSMT_SUB_PIN = 8'h27;
   localparam logic [7:0] MSMT_SRC_EEPROM = 8'h02;
   localparam logic [31:0] MSMT_CFG_MAX = 32'h0000_00FF;
   localparam logic [31:0] MSMT_PIN_BYTES = 32'h0000_0004;
   localparam int MSMT_DIR_BIT = 7;
   localparam int MSMT_DD_DRIVE_BIT = 15;
   // ==========================================================================
   // modes and states
   typedef enum logic [1:0] {
      MSMT_MODE_NORMAL = 2'b00,
      MSMT_MODE_LEGACY = 2'b01,
      MSMT_MODE_MFG = 2'b10
   } msmt_mode_type;
   typedef enum logic [3:0] {
      MSMT_ST_STRAP = 4'b0000,
      MSMT_ST_SIG0 = 4'b0001,
      MSMT_ST_SIG1 = 4'b0010,
      MSMT_ST_DESIG = 4'b0011,
      MSMT_ST_DECIDE = 4'b0100,
      MSMT_ST_IDLE = 4'b0101,
      MSMT_ST_CFG_GET = 4'b0110,
      MSMT_ST_CFG_WR = 4'b0111,
      MSMT_ST_CFG_RD = 4'b1000,
      MSMT_ST_SEND = 4'b1001,
      MSMT_ST_PIN_GET = 4'b1010
   } msmt_state_type;
   // ==========================================================================
   // carriers
   typedef struct packed {
      logic [127:0] cb;
      logic [31:0] len;
      logic [7:0] flags;
   } msmt_cbw_type;
   typedef struct packed {
      logic drive_reset_line_n;
      logic [1:0] cs_n;
      logic drive_power_valid;
      logic [1:0] da;
      logic dmack_n;
      logic dior_n;
      logic diow_n;
      logic [15:0] dd;
   } msmt_pins_type;
   typedef struct packed {
      logic drive_reset_line_n;
      logic da2;
      logic [1:0] cs_n;
      logic drive_power_valid;
      logic [1:0] da;
      logic intrq;
      logic bus_power_to_drive_en;
      logic dmarq;
      logic iordy;
      logic dmack_n;
      logic dior_n;
      logic diow_n;
      logic [15:0] dd;
   } msmt_pin_in_type;
endpackage
